// ===== design/oled_host_port.sv
/*
  Host write port of an OLED controller: parallel or serial byte intake,
  relay of bus pins for cascaded devices, two-byte command receiver,
  X/Y write pointers and a dual-port frame memory.
  Assumes all host pins are asynchronous to clk and the serial clock is
  much slower than clk so that every edge is seen.
*/
// Behaviour
// - Strap high selects parallel bus, low selects serial; only that port takes bytes.
// - Serial data and shift clock arrive on data bits 7 and 6.
// - Serial data and shift clock are relayed on relay bits 7 and 6.
// - Parallel data, both selects and store pulse are relayed for downstream devices.
// - First select addresses master devices, second select the slave devices.
// - After reset the receiver waits for a command code or pixel byte.
// - An accepted command code moves the receiver to await its data byte.
// - Awaiting command data, any command or pixel byte returns receiver to idle.
// - Serial mode with both selects high clears the relay outputs.
// - Data/command low marks command bytes, high marks pixel bytes.
// - A command is exactly a code byte followed by one data byte.
// - A pixel byte during an unfinished command drops back to awaiting a code.
// - Frame memory is dual port: host write only, refresh read only.
// - One command loads the column pointer, another the row pointer.
// - A format command holds column step, row step and the pixel format.
// - 16-level: two pixels a byte, X to 7Fh, Y to 47h.
// - 4-level: four pixels a byte, X to 3Fh, Y to 8Fh.
// - 64-level mode 1: one pixel a byte, X to 7Fh, Y to 47h.
// - Two-colour operation is refused in 64-level mode 1.
// - Mono keeps four frames; 64-level mode 2 one frame of 256 by 36.
// - Both steps advance both pointers; at X limit only Y advances.
`timescale 1ns/1ps
`default_nettype none
module oled_host_port #(
  parameter int unsigned RAM_DEPTH = oled_host_pkg::RAM_DEPTH,
  parameter int unsigned RAM_AW = oled_host_pkg::RAM_AW
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Straps
  input wire logic parallel_select,
  input wire logic dual_colour_strap,
  // Host pins
  input wire logic [7:0] host_data,
  input wire logic master_select_n,
  input wire logic slave_select_n,
  input wire logic store_pulse_n,
  input wire logic pixel_or_command,
  // Relay pins
  output logic [7:0] relay_data_ff,
  output logic master_select_relay_n_ff,
  output logic slave_select_relay_n_ff,
  output logic store_pulse_relay_n_ff,
  output logic pixel_or_command_relay_ff,
  // Intake status
  output logic intake_ready_ff,
  // Completed commands
  output logic cmd_valid_ff,
  input wire logic cmd_ready,
  output oled_host_pkg::command_t cmd_ff,
  // Configuration state
  output logic [7:0] col_pointer_ff,
  output logic [7:0] row_pointer_ff,
  output logic [2:0] pixel_format_field_ff,
  output logic col_auto_step_ff,
  output logic row_auto_step_ff,
  output logic dual_colour_active_ff,
  // Refresh read port
  input wire logic [RAM_AW-1:0] refresh_addr,
  output logic [7:0] refresh_data_ff
);
  typedef enum logic {WAIT_CODE, WAIT_ARG} rx_state_t;

  // Pin synchronisers
  localparam int unsigned NPIN = 14;
  wire [NPIN-1:0] pin_raw = {parallel_select, dual_colour_strap, pixel_or_command,
    store_pulse_n, slave_select_n, master_select_n, host_data};
  logic [NPIN-1:0] meta_ff;
  logic [NPIN-1:0] pin_ff;
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          meta_ff[gi] <= 1'b1;
          pin_ff[gi] <= 1'b1;
        end else begin
          meta_ff[gi] <= pin_raw[gi];
          pin_ff[gi] <= meta_ff[gi];
        end
      end
    end
  endgenerate

  wire [7:0] s_data = pin_ff[7:0];
  wire s_msel_n = pin_ff[8];
  wire s_ssel_n = pin_ff[9];
  wire s_store_n = pin_ff[10];
  wire s_dc = pin_ff[11];
  wire s_dual = pin_ff[12];
  wire s_par = pin_ff[NPIN-1];
  wire sel_both = !s_msel_n && !s_ssel_n;
  wire sel_none = s_msel_n && s_ssel_n;
  // Serial lines on bits 7, 6
  wire s_bit = s_data[7];
  wire s_sclk = s_data[6];

  // Edge detection on synchronised pins
  logic store_prev_ff;
  logic sclk_prev_ff;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      store_prev_ff <= 1'b1;
      sclk_prev_ff <= 1'b1;
    end else begin
      store_prev_ff <= s_store_n;
      sclk_prev_ff <= s_sclk;
    end
  end
  wire store_rise = s_store_n && !store_prev_ff;
  wire sclk_rise = s_sclk && !sclk_prev_ff;

  // Parallel write on store pulse end
  wire par_take = s_par && store_rise && sel_both;

  logic [2:0] bit_cnt_ff;
  logic [6:0] shift_ff;
  wire ser_shift = !s_par && sclk_rise && sel_both;
  wire ser_take = ser_shift && (bit_cnt_ff == 3'(oled_host_pkg::SER_LAST_BIT));
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt_ff <= '0;
      shift_ff <= '0;
    end else if (s_par || !sel_both) begin
      bit_cnt_ff <= '0;
    end else if (ser_shift) begin
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      shift_ff <= {shift_ff[5:0], s_bit};
    end
  end

  oled_host_pkg::host_byte_t in_byte;
  assign in_byte.is_pixel = s_dc;
  assign in_byte.value = s_par ? s_data : {shift_ff, s_bit};

  // Intake buffer
  wire in_ready;
  wire out_valid;
  oled_host_pkg::host_byte_t out_byte;
  wire cmd_stall = cmd_valid_ff && !cmd_ready;
  wire pop = out_valid && !cmd_stall;
  byte_buffer #(.WIDTH($bits(oled_host_pkg::host_byte_t)), .DEPTH(2)) u_buf (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(par_take || ser_take),
    .in_ready(in_ready),
    .in_data(in_byte),
    .out_valid(out_valid),
    .out_ready(!cmd_stall),
    .out_data(out_byte)
  );

  // Receiver state
  rx_state_t state_ff;
  rx_state_t nxt_state;
  logic [7:0] code_ff;
  wire take_pixel = pop && out_byte.is_pixel;
  wire take_cmd = pop && !out_byte.is_pixel;
  wire cmd_done = take_cmd && (state_ff == WAIT_ARG);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      WAIT_CODE: begin
        if (take_cmd) begin
          nxt_state = WAIT_ARG;
        end
      end
      WAIT_ARG: begin
        if (pop) begin
          nxt_state = WAIT_CODE;
        end
      end
      default: begin
        nxt_state = WAIT_CODE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= WAIT_CODE;
      code_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      if (take_cmd && state_ff == WAIT_CODE) begin
        code_ff <= out_byte.value;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_valid_ff <= 1'b0;
      cmd_ff <= '0;
    end else if (cmd_done) begin
      cmd_valid_ff <= 1'b1;
      cmd_ff <= '{code: code_ff, arg: out_byte.value};
    end else if (cmd_ready) begin
      cmd_valid_ff <= 1'b0;
    end
  end

  // Format limits
  wire fmt_g4 = (pixel_format_field_ff == oled_host_pkg::FMT_GRAY4);
  wire fmt_mono = (pixel_format_field_ff == oled_host_pkg::FMT_MONO);
  wire fmt_g64b = (pixel_format_field_ff == oled_host_pkg::FMT_GRAY64_B);
  wire fmt_g64a = (pixel_format_field_ff == oled_host_pkg::FMT_GRAY64_A);
  wire narrow_x = fmt_g4 || fmt_mono;
  wire [7:0] x_max = narrow_x ? oled_host_pkg::X_MAX_GRAY4 :
    fmt_g64b ? oled_host_pkg::X_MAX_GRAY64_B : oled_host_pkg::X_MAX_GRAY16;
  wire [7:0] y_max = narrow_x ? oled_host_pkg::Y_MAX_GRAY4 :
    fmt_g64b ? oled_host_pkg::Y_MAX_GRAY64_B : oled_host_pkg::Y_MAX_GRAY16;
  wire x_end = (col_pointer_ff >= x_max);
  wire y_end = (row_pointer_ff >= y_max);
  wire [7:0] y_next = y_end ? 8'h00 : row_pointer_ff + 8'h01;
  wire [7:0] x_next = x_end ? 8'h00 : col_pointer_ff + 8'h01;

  wire set_col = cmd_done && code_ff == oled_host_pkg::CMD_COL_SET;
  wire set_row = cmd_done && code_ff == oled_host_pkg::CMD_ROW_SET;
  wire set_fmt = cmd_done && code_ff == oled_host_pkg::CMD_FORMAT;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      col_pointer_ff <= oled_host_pkg::PTR_RST;
      row_pointer_ff <= oled_host_pkg::PTR_RST;
      pixel_format_field_ff <= oled_host_pkg::FMT_RST;
      col_auto_step_ff <= 1'b0;
      row_auto_step_ff <= 1'b0;
    end else begin
      if (set_fmt) begin
        col_auto_step_ff <= out_byte.value[oled_host_pkg::COL_STEP_POS];
        row_auto_step_ff <= out_byte.value[oled_host_pkg::ROW_STEP_POS];
        pixel_format_field_ff <= out_byte.value[oled_host_pkg::FMT_LSB +: 3];
      end
      if (set_col) begin
        col_pointer_ff <= out_byte.value;
      end else if (take_pixel && col_auto_step_ff && !(row_auto_step_ff && x_end)) begin
        col_pointer_ff <= x_next;
      end
      if (set_row) begin
        row_pointer_ff <= out_byte.value;
      end else if (take_pixel && row_auto_step_ff) begin
        row_pointer_ff <= y_next;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dual_colour_active_ff <= 1'b0;
    end else begin
      dual_colour_active_ff <= s_dual && !fmt_g64a && !fmt_g64b;
    end
  end

  wire [15:0] row_base = fmt_g64b ? {row_pointer_ff, 8'h00} :
    narrow_x ? {2'b00, row_pointer_ff, 6'h00} : {1'b0, row_pointer_ff, 7'h00};
  wire [15:0] wr_addr_w = row_base + {8'h00, col_pointer_ff};
  wire wr_ok = take_pixel && (wr_addr_w < 16'(RAM_DEPTH));
  wire [RAM_AW-1:0] wr_addr = wr_addr_w[RAM_AW-1:0];

  logic [7:0] frame_mem [RAM_DEPTH];
  always_ff @(posedge clk) begin
    if (wr_ok) begin
      frame_mem[wr_addr] <= out_byte.value;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      refresh_data_ff <= '0;
    end else begin
      refresh_data_ff <= frame_mem[refresh_addr];
    end
  end

  wire relay_clear = !s_par && sel_none;
  wire [7:0] relay_data_w = s_par ? s_data : {s_bit, s_sclk, 6'h00};
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      relay_data_ff <= '0;
      master_select_relay_n_ff <= 1'b1;
      slave_select_relay_n_ff <= 1'b1;
      store_pulse_relay_n_ff <= 1'b1;
      pixel_or_command_relay_ff <= 1'b0;
      intake_ready_ff <= 1'b0;
    end else begin
      intake_ready_ff <= in_ready;
      if (relay_clear) begin
        relay_data_ff <= '0;
        master_select_relay_n_ff <= 1'b1;
        slave_select_relay_n_ff <= 1'b1;
        store_pulse_relay_n_ff <= 1'b1;
        pixel_or_command_relay_ff <= 1'b0;
      end else begin
        relay_data_ff <= relay_data_w;
        master_select_relay_n_ff <= s_msel_n;
        slave_select_relay_n_ff <= s_ssel_n;
        store_pulse_relay_n_ff <= s_par ? s_store_n : 1'b1;
        pixel_or_command_relay_ff <= s_dc;
      end
    end
  end
endmodule
`default_nettype wire

// ===== design/oled_host_pkg.sv
/*
  Shared constants and carrier types for the OLED host write port:
  frame memory geometry, command codes, configuration fields, pixel formats.
  Assumes nothing of its surroundings; included by package scope only.
*/
package oled_host_pkg;

  // Frame memory geometry
  localparam int unsigned RAM_DEPTH = 9216;
  localparam int unsigned RAM_AW = 14;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned SER_LAST_BIT = 7;

  // Command codes
  localparam logic [7:0] CMD_COL_SET = 8'h20;
  localparam logic [7:0] CMD_ROW_SET = 8'h21;
  localparam logic [7:0] CMD_FORMAT = 8'h22;

  // Configuration byte field positions
  localparam int unsigned COL_STEP_POS = 0;
  localparam int unsigned ROW_STEP_POS = 1;
  localparam int unsigned FMT_LSB = 2;

  // Pixel formats
  localparam logic [2:0] FMT_GRAY16 = 3'h0;
  localparam logic [2:0] FMT_GRAY4 = 3'h1;
  localparam logic [2:0] FMT_GRAY64_A = 3'h2;
  localparam logic [2:0] FMT_GRAY64_B = 3'h3;
  localparam logic [2:0] FMT_MONO = 3'h4;

  // Pointer limits per format
  localparam logic [7:0] X_MAX_GRAY16 = 8'h7f;
  localparam logic [7:0] Y_MAX_GRAY16 = 8'h47;
  localparam logic [7:0] X_MAX_GRAY4 = 8'h3f;
  localparam logic [7:0] Y_MAX_GRAY4 = 8'h8f;
  localparam logic [7:0] X_MAX_GRAY64_B = 8'hff;
  localparam logic [7:0] Y_MAX_GRAY64_B = 8'h23;

  // Reset values
  localparam logic [2:0] FMT_RST = FMT_GRAY16;
  localparam logic [7:0] PTR_RST = 8'h00;

  typedef struct packed {
    logic is_pixel;
    logic [7:0] value;
  } host_byte_t;

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] arg;
  } command_t;

endpackage

// ===== design/byte_buffer.sv
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes producer and consumer on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module byte_buffer #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] slot_ff [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [CW-1:0] count_ff;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [PW-1:0] wr_last = PW'(DEPTH - 1);

  assign in_ready = (count_ff != CW'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data = slot_ff[rd_ptr_ff];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == wr_last) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == wr_last) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      slot_ff[wr_ptr_ff] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ===== test/oled_host_port_sva.sv
/* Checker for the host port: relay pins, command hand-off, pointer loads.
   Assumes it is bound to oled_host_port, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module oled_host_port_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Host pins
  input wire logic parallel_select,
  input wire logic [7:0] host_data,
  input wire logic master_select_n,
  input wire logic slave_select_n,
  input wire logic store_pulse_n,
  input wire logic pixel_or_command,
  // Relay pins
  input wire logic [7:0] relay_data_ff,
  input wire logic master_select_relay_n_ff,
  input wire logic slave_select_relay_n_ff,
  input wire logic store_pulse_relay_n_ff,
  input wire logic pixel_or_command_relay_ff,
  // Commands and state
  input wire logic cmd_valid_ff,
  input wire logic cmd_ready,
  input wire oled_host_pkg::command_t cmd_ff,
  input wire logic [7:0] col_pointer_ff,
  input wire logic [7:0] row_pointer_ff,
  input wire logic [2:0] pixel_format_field_ff,
  input wire logic col_auto_step_ff,
  input wire logic row_auto_step_ff,
  input wire logic dual_colour_active_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence par_held;
    parallel_select [*6];
  endsequence
  sequence ser_busy;
    (!parallel_select && !master_select_n && !slave_select_n) [*6];
  endsequence
  sequence ser_idle;
    (!parallel_select && master_select_n && slave_select_n) [*6];
  endsequence
  sequence cmd_new(logic [7:0] c);
    $rose(cmd_valid_ff) && cmd_ff.code == c;
  endsequence
  AST_REL_DATA: assert property (par_held |-> relay_data_ff == $past(host_data, 3))
    else $error("relay data differs from bus");
  AST_REL_STROBES: assert property (par_held |-> master_select_relay_n_ff == $past(master_select_n, 3)
    && slave_select_relay_n_ff == $past(slave_select_n, 3) && store_pulse_relay_n_ff == $past(store_pulse_n, 3))
    else $error("relay strobes differ from bus");
  AST_REL_DC: assert property (par_held |-> pixel_or_command_relay_ff == $past(pixel_or_command, 3))
    else $error("relayed data or command flag differs from bus");
  AST_SER_RELAY: assert property (ser_busy |-> relay_data_ff == {$past(host_data[7:6], 3), 6'h00})
    else $error("serial relay wrong");
  AST_SER_CLEAR: assert property (ser_idle |-> relay_data_ff == 8'h00 && master_select_relay_n_ff
    && slave_select_relay_n_ff && store_pulse_relay_n_ff && !pixel_or_command_relay_ff)
    else $error("serial relay not cleared");
  AST_COL_LOAD: assert property (cmd_new(oled_host_pkg::CMD_COL_SET) |-> col_pointer_ff == cmd_ff.arg)
    else $error("column pointer not loaded");
  AST_ROW_LOAD: assert property (cmd_new(oled_host_pkg::CMD_ROW_SET) |-> row_pointer_ff == cmd_ff.arg)
    else $error("row pointer not loaded");
  AST_FMT_LOAD: assert property (cmd_new(oled_host_pkg::CMD_FORMAT) |-> pixel_format_field_ff == cmd_ff.arg[4:2]
    && col_auto_step_ff == cmd_ff.arg[0] && row_auto_step_ff == cmd_ff.arg[1])
    else $error("format not loaded");
  AST_CMD_HOLD: assert property (cmd_valid_ff && !cmd_ready |=> cmd_valid_ff && $stable(cmd_ff))
    else $error("command dropped while stalled");
  AST_NO_DUAL: assert property ((pixel_format_field_ff == oled_host_pkg::FMT_GRAY64_A) [*2]
    |-> !dual_colour_active_ff)
    else $error("two colours in 64 level mode");
endmodule
bind oled_host_port oled_host_port_sva u_oled_host_port_sva (.*);
`default_nettype wire

// ===== test/host_mcu_model.sv
/* Host controller model driving the parallel or serial write port.
   Assumes the caller spaces bytes; all pins change after clk edges. */
`timescale 1ns/1ps
`default_nettype none
module host_mcu_model (
  // Clock
  input wire logic clk,
  // Host pins
  output logic parallel_select,
  output logic [7:0] host_data,
  output logic master_select_n,
  output logic slave_select_n,
  output logic store_pulse_n,
  output logic pixel_or_command
);
  initial begin
    parallel_select = 1'b1;
    host_data = 8'h00;
    master_select_n = 1'b1;
    slave_select_n = 1'b1;
    store_pulse_n = 1'b1;
    pixel_or_command = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic set_mode(input logic par);
    @(posedge clk);
    parallel_select <= par;
    wait_clk(8);
  endtask
  task automatic put_byte(input logic dc, input logic [7:0] v, input logic bad_sel);
    @(posedge clk);
    pixel_or_command <= dc;
    master_select_n <= bad_sel;
    slave_select_n <= 1'b0;
    host_data <= parallel_select ? v : 8'h00;
    wait_clk(4);
    if (parallel_select) begin
      store_pulse_n <= 1'b0;
      wait_clk(4);
      store_pulse_n <= 1'b1;
      wait_clk(4);
    end else begin
      for (int i = 7; i >= 0; i--) begin
        host_data <= {v[i], 7'h00};
        wait_clk(4);
        host_data <= {v[i], 7'h40};
        wait_clk(4);
      end
      host_data <= {v[0], 7'h00};
      wait_clk(4);
    end
    master_select_n <= 1'b1;
    slave_select_n <= 1'b1;
    host_data <= parallel_select ? ~v : {~v[0], 7'h00};
    wait_clk(4);
  endtask
endmodule
`default_nettype wire

// ===== test/oled_host_port_bench.sv
/* Self-checking bench for the host write port.
   Assumes the host model and checker files are compiled with it. */
`timescale 1ns/1ps
`default_nettype none
module oled_host_port_bench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic dual_colour_strap, cmd_ready = 1'b0, hold = 1'b0, rd_req = 1'b0, rd_seen = 1'b0;
  logic [13:0] refresh_addr;
  logic [31:0] seed = 32'hed03;
  wire parallel_select, master_select_n, slave_select_n, store_pulse_n, pixel_or_command;
  wire [7:0] host_data;
  logic intake_ready_ff, cmd_valid_ff, col_auto_step_ff, row_auto_step_ff, dual_colour_active_ff;
  oled_host_pkg::command_t cmd_ff;
  logic [7:0] col_pointer_ff, row_pointer_ff, refresh_data_ff;
  logic [2:0] pixel_format_field_ff;
  oled_host_pkg::command_t cmd_q[$];
  logic [7:0] mem_q[$];
  int n_fail = 0;
  int checked = 0;
  always #4 clk = ~clk;
  host_mcu_model u_host_mcu_model (.clk(clk), .parallel_select(parallel_select), .host_data(host_data),
    .master_select_n(master_select_n), .slave_select_n(slave_select_n), .store_pulse_n(store_pulse_n),
    .pixel_or_command(pixel_or_command));
  oled_host_port u_oled_host_port (.clk(clk), .arst_n(arst_n), .parallel_select(parallel_select),
    .dual_colour_strap(dual_colour_strap), .host_data(host_data), .master_select_n(master_select_n),
    .slave_select_n(slave_select_n), .store_pulse_n(store_pulse_n), .pixel_or_command(pixel_or_command),
    .relay_data_ff(), .master_select_relay_n_ff(), .slave_select_relay_n_ff(), .store_pulse_relay_n_ff(),
    .pixel_or_command_relay_ff(), .intake_ready_ff(intake_ready_ff), .cmd_valid_ff(cmd_valid_ff),
    .cmd_ready(cmd_ready), .cmd_ff(cmd_ff), .col_pointer_ff(col_pointer_ff), .row_pointer_ff(row_pointer_ff),
    .pixel_format_field_ff(pixel_format_field_ff), .col_auto_step_ff(col_auto_step_ff),
    .row_auto_step_ff(row_auto_step_ff), .dual_colour_active_ff(dual_colour_active_ff),
    .refresh_addr(refresh_addr), .refresh_data_ff(refresh_data_ff));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Random consumer stalls and queued result checks
  always @(posedge clk) begin
    seed <= xs(seed);
    cmd_ready <= seed[5] & ~hold;
    rd_seen <= rd_req;
    if (cmd_valid_ff === 1'b1 && cmd_ready === 1'b1) chk(cmd_ff, cmd_q.size() ? cmd_q.pop_front() : ~cmd_ff);
    if (rd_seen) chk({8'h00, refresh_data_ff}, {8'h00, mem_q.pop_front()});
  end
  task automatic send_cmd(input logic [7:0] code, input logic [7:0] arg);
    cmd_q.push_back({code, arg});
    u_host_mcu_model.put_byte(1'b0, code, 1'b0);
    u_host_mcu_model.put_byte(1'b0, arg, 1'b0);
  endtask
  task automatic settle();
    int n = 0;
    repeat (8) @(posedge clk);
    while (cmd_valid_ff !== 1'b0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
  endtask
  task automatic rd_mem(input int unsigned a, input logic [7:0] v);
    @(posedge clk);
    refresh_addr <= a[13:0];
    rd_req <= 1'b1;
    mem_q.push_back(v);
    @(posedge clk);
    rd_req <= 1'b0;
  endtask
  task automatic ptr_is(input logic [7:0] x, input logic [7:0] y);
    chk({col_pointer_ff, row_pointer_ff}, {x, y});
  endtask
  task automatic px_case(input logic [2:0] f, input logic [1:0] st, input logic [7:0] x, input logic [7:0] y,
      input logic [7:0] ex, input logic [7:0] ey, input int unsigned stride);
    logic [7:0] v;
    dual_colour_strap <= seed[9];
    send_cmd(oled_host_pkg::CMD_FORMAT, {3'h0, f, st});
    send_cmd(oled_host_pkg::CMD_COL_SET, x);
    send_cmd(oled_host_pkg::CMD_ROW_SET, y);
    settle();
    chk({11'h000, pixel_format_field_ff, row_auto_step_ff, col_auto_step_ff}, {11'h000, f, st});
    chk({15'h0000, dual_colour_active_ff}, {15'h0000, dual_colour_strap && f != oled_host_pkg::FMT_GRAY64_A
      && f != oled_host_pkg::FMT_GRAY64_B});
    ptr_is(x, y);
    v = seed[7:0];
    u_host_mcu_model.put_byte(1'b1, v, 1'b0);
    settle();
    ptr_is(ex, ey);
    rd_mem(y * stride + x, v);
  endtask
  initial begin
    dual_colour_strap = 1'b1;
    refresh_addr = 14'h0000;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk({cmd_valid_ff, 7'h00, col_pointer_ff}, 16'h0000);
    px_case(oled_host_pkg::FMT_GRAY16, 2'h3, 8'h7f, 8'h05, 8'h7f, 8'h06, 128);
    px_case(oled_host_pkg::FMT_GRAY4, 2'h1, 8'h3f, 8'h8f, 8'h00, 8'h8f, 64);
    px_case(oled_host_pkg::FMT_GRAY64_A, 2'h2, 8'h7f, 8'h47, 8'h7f, 8'h00, 128);
    px_case(oled_host_pkg::FMT_GRAY64_B, 2'h0, 8'hff, 8'h23, 8'hff, 8'h23, 256);
    px_case(oled_host_pkg::FMT_MONO, 2'h3, 8'h10, 8'h20, 8'h11, 8'h21, 64);
    // Pixel byte cuts a half command
    u_host_mcu_model.put_byte(1'b0, oled_host_pkg::CMD_COL_SET, 1'b0);
    u_host_mcu_model.put_byte(1'b1, 8'h3c, 1'b0);
    send_cmd(oled_host_pkg::CMD_ROW_SET, 8'h07);
    settle();
    ptr_is(8'h12, 8'h07);
    rd_mem(8'h21 * 64 + 8'h11, 8'h3c);
    u_host_mcu_model.put_byte(1'b1, 8'h99, 1'b1);
    send_cmd(8'h55, seed[7:0]);
    settle();
    ptr_is(8'h12, 8'h07);
    // Consumer stalled: buffer fills and refuses
    hold <= 1'b1;
    send_cmd(oled_host_pkg::CMD_COL_SET, 8'h31);
    send_cmd(oled_host_pkg::CMD_ROW_SET, 8'h09);
    chk({15'h0000, intake_ready_ff}, 16'h0000);
    hold <= 1'b0;
    settle();
    ptr_is(8'h31, 8'h09);
    u_host_mcu_model.set_mode(1'b0);
    send_cmd(oled_host_pkg::CMD_COL_SET, 8'h2a);
    u_host_mcu_model.put_byte(1'b1, 8'h77, 1'b1);
    u_host_mcu_model.put_byte(1'b1, 8'h5e, 1'b0);
    settle();
    ptr_is(8'h2b, 8'h0a);
    rd_mem(8'h09 * 64 + 8'h2a, 8'h5e);
    stop_test();
  end
  initial begin
    #300000;
    n_fail++;
    stop_test();
  end
endmodule
`default_nettype wire
